// ---- hw/ppoc_port_power.sv ----
// Summary of operation
// - One shared pin drives power, senses overcurrent.
// - Reset comes up in individual port mode.
// - Ganged mode set only by register write.
// - Ganged pin controls and senses all ports.
// - Ganged overcurrent flags every port together.
// - Power off drives pin low, pull-up off.
// - Power on releases driver, enables pull-up.
// - Enabled port pin sampled continuously, low suspect.
// - Low held minimum width flags overcurrent.
// - Two low groups within window flag overcurrent.
// - Ignore pin for lockout time after turn-on.
// - Minimum width field bits 3:0, default five.
// - Charging supply presence shown per port pin; in ganged mode any port's bc bit powers the ganged pin instead.
// - Double window 8-bit register, default twenty.
// - Lockout 8-bit register, default ten ms.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps
module ppoc_port_power #(
   parameter int NPORT = 6,
   parameter int TICK_CYCLES = ppoc_pkg::TICK_CYC
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ppoc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [ppoc_pkg::DAT_W-1:0] wb_dat_i,
   output logic [ppoc_pkg::DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NPORT-1:0] port_power_sense_pin_in,
   output logic [NPORT-1:0] port_power_sense_pin_out,
   output logic [NPORT-1:0] port_power_sense_pin_oe,
   output logic [NPORT-1:0] port_pullup_en,
   input wire logic ganged_power_sense_pin_in,
   output logic ganged_power_sense_pin_out,
   output logic ganged_power_sense_pin_oe,
   output logic ganged_pullup_en,
   output logic irq
);

   // Width of the millisecond prescaler.
   localparam int TW = $clog2(TICK_CYCLES + 1);
   // Last prescaler count before the tick.
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   // All state of the block in one record.
   typedef struct packed {
      logic [NPORT-1:0] s1; // First synchroniser stage.
      logic [NPORT-1:0] s2; // Second synchroniser stage.
      logic gs1; // Ganged pin, first stage.
      logic gs2; // Ganged pin, second stage.
      logic [NPORT-1:0] prev; // Previous sample was low.
      ppoc_pkg::ppoc_phase_t [NPORT-1:0] ph; // Power phase.
      logic [NPORT-1:0][ppoc_pkg::TMR_W-1:0] lcnt; // Lockout left.
      logic [NPORT-1:0][ppoc_pkg::TMR_W-1:0] wcnt; // Window left.
      logic [NPORT-1:0][ppoc_pkg::MINW_W-1:0] run; // Low ms seen.
      logic [NPORT-1:0] armed; // First low group seen.
      logic [TW-1:0] tcnt; // Prescaler.
      logic tick; // One-cycle millisecond strobe.
      logic [ppoc_pkg::MINW_W-1:0] minw; // Single pulse width.
      logic [ppoc_pkg::TMR_W-1:0] dblw; // Double pulse window.
      logic [ppoc_pkg::TMR_W-1:0] lock; // Turn-on lockout.
      logic [NPORT-1:0] pwr; // Software power enables.
      logic [NPORT-1:0] bc; // Charging supply indication.
      logic gang; // Ganged mode.
      logic [NPORT-1:0] stat; // Sticky overcurrent status.
      logic [NPORT-1:0] mask; // Interrupt mask.
      logic ack; // Bus acknowledge.
      logic [ppoc_pkg::DAT_W-1:0] dat; // Bus read data.
      logic [NPORT-1:0] drv; // Pin drive level, always low.
      logic [NPORT-1:0] oe; // Port pin drivers on.
      logic [NPORT-1:0] pu; // Port pull-ups on.
      logic g_oe; // Ganged pin driver on.
      logic g_pu; // Ganged pull-up on.
      logic irq; // Interrupt level.
   } ppoc_state_t;

   ppoc_state_t st_r;
   ppoc_state_t st_nxt;

   // Next-state logic for the whole block.
   always_comb begin
      logic [NPORT-1:0] en;
      logic [NPORT-1:0] low;
      logic [NPORT-1:0] oc;
      logic [NPORT-1:0] clr;
      logic gen;
      logic req;
      logic wr;
      logic [15:0] idx;
      en = '0;
      low = '0;
      oc = '0;
      clr = '0;
      gen = 1'b0;
      req = 1'b0;
      wr = 1'b0;
      idx = '0;
      st_nxt = st_r;

      // Pins cross into the clock domain through two flops.
      st_nxt.s1 = port_power_sense_pin_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.gs1 = ganged_power_sense_pin_in;
      st_nxt.gs2 = st_r.gs1;

      // Free-running millisecond prescaler.
      // It is shared by all ports, so a timed span carries up to one
      // tick of phase error; the lockout spends a spare tick for it.
      st_nxt.tick = 1'b0;
      if (st_r.tcnt == TICK_LAST) begin
         st_nxt.tcnt = '0;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.tcnt = st_r.tcnt + 1'b1;
      end

      // The ganged pin carries power for all ports as one.
      gen = (|st_r.pwr) | (|st_r.bc);
      for (int i = 0; i < NPORT; i++) begin
         if (st_r.gang) begin
            // Every channel watches the same pin, so they fire together.
            en[i] = gen;
            low[i] = !st_r.gs2;
         end else begin
            // A charging-capable port keeps its switch on as its sign.
            en[i] = st_r.pwr[i] | st_r.bc[i];
            low[i] = !st_r.s2[i];
         end
      end

      // Per-port lockout and overcurrent filter.
      for (int i = 0; i < NPORT; i++) begin
         case (st_r.ph[i])
            ppoc_pkg::PH_OFF: begin
               // Counters restart whenever power comes on.
               if (en[i]) begin
                  // A zero lockout senses at once; software should not
                  // program it, but the filter must not hang on it.
                  if (st_r.lock == '0) begin
                     st_nxt.ph[i] = ppoc_pkg::PH_SENSE;
                  end else begin
                     st_nxt.ph[i] = ppoc_pkg::PH_LOCK;
                  end
                  st_nxt.lcnt[i] = st_r.lock;
                  st_nxt.run[i] = '0;
                  st_nxt.armed[i] = 1'b0;
                  st_nxt.prev[i] = 1'b0;
               end
            end
            ppoc_pkg::PH_LOCK: begin
               // The pin is ignored while the supply ramps.
               if (!en[i]) begin
                  st_nxt.ph[i] = ppoc_pkg::PH_OFF;
               end else if (st_r.tick) begin
                  // The first tick may come one cycle after turn-on, so
                  // one extra tick is spent to never cut the lockout
                  // short; it lasts between lock and lock plus one ms.
                  if (st_r.lcnt[i] == '0) begin
                     st_nxt.ph[i] = ppoc_pkg::PH_SENSE;
                  end else begin
                     st_nxt.lcnt[i] = st_r.lcnt[i] - 1'b1;
                  end
               end
            end
            ppoc_pkg::PH_SENSE: begin
               if (!en[i]) begin
                  st_nxt.ph[i] = ppoc_pkg::PH_OFF;
               end else begin
                  st_nxt.prev[i] = low[i];
                  // A low pin is pulled down by the switch on a fault.
                  if (low[i]) begin
                     if (st_r.run[i] >= st_r.minw) begin
                        oc[i] = 1'b1;
                     end
                     if (st_r.tick && st_r.run[i] != 4'hf) begin
                        st_nxt.run[i] = st_r.run[i] + 1'b1;
                     end
                  end else begin
                     st_nxt.run[i] = '0;
                  end
                  // Rolling window opened by the first low group.
                  if (st_r.armed[i] && st_r.tick) begin
                     if (st_r.wcnt[i] <= 8'h01) begin
                        st_nxt.armed[i] = 1'b0;
                     end else begin
                        st_nxt.wcnt[i] = st_r.wcnt[i] - 1'b1;
                     end
                  end
                  // A new group starts on a high-to-low change.
                  if (low[i] && !st_r.prev[i]) begin
                     if (st_r.armed[i]) begin
                        oc[i] = 1'b1;
                     end else begin
                        st_nxt.armed[i] = 1'b1;
                        st_nxt.wcnt[i] = st_r.dblw;
                     end
                  end
                  // After a detection the filter starts over.
                  if (oc[i]) begin
                     st_nxt.run[i] = '0;
                     st_nxt.armed[i] = 1'b0;
                  end
               end
            end
            default: begin
               st_nxt.ph[i] = ppoc_pkg::PH_OFF;
            end
         endcase
      end

      // Pin drivers: low with pull-up off when unpowered, else released.
      // The drive level is a register of zeros, so every pin output
      // comes from a flop; an open-drain pin never drives high.
      st_nxt.drv = '0;
      for (int i = 0; i < NPORT; i++) begin
         // Unused port pins stay driven low in ganged mode.
         st_nxt.oe[i] = st_r.gang | !en[i];
         st_nxt.pu[i] = !(st_r.gang | !en[i]);
      end
      st_nxt.g_oe = !(st_r.gang && gen);
      st_nxt.g_pu = st_r.gang && gen;

      // Classic Wishbone slave: one wait state, then ack for a cycle.
      // Read data is fetched at the taking edge and shown with ack.
      // A write lands only at the edge at which the master samples ack.
      req = wb_cyc_i && wb_stb_i && !st_r.ack;
      wr = wb_cyc_i && wb_stb_i && st_r.ack && wb_we_i && wb_sel_i[0];
      idx = wb_adr_i[ppoc_pkg::ADR_W-1:2];
      st_nxt.ack = req;
      st_nxt.dat = '0;
      if (req || wr) begin
         case (idx)
            ppoc_pkg::IDX_LOCK: begin
               st_nxt.dat[ppoc_pkg::TMR_W-1:0] = st_r.lock;
               if (wr) begin
                  st_nxt.lock = wb_dat_i[ppoc_pkg::TMR_W-1:0];
               end
            end
            ppoc_pkg::IDX_MINW: begin
               // Upper four bits are reserved and read as zero.
               st_nxt.dat[ppoc_pkg::MINW_W-1:0] = st_r.minw;
               if (wr) begin
                  st_nxt.minw = wb_dat_i[ppoc_pkg::MINW_W-1:0];
               end
            end
            ppoc_pkg::IDX_DBLW: begin
               st_nxt.dat[ppoc_pkg::TMR_W-1:0] = st_r.dblw;
               if (wr) begin
                  st_nxt.dblw = wb_dat_i[ppoc_pkg::TMR_W-1:0];
               end
            end
            ppoc_pkg::IDX_PWR: begin
               st_nxt.dat[NPORT-1:0] = st_r.pwr;
               if (wr) begin
                  st_nxt.pwr = wb_dat_i[NPORT-1:0];
               end
            end
            ppoc_pkg::IDX_CFG: begin
               // Only a register write can change the port mode.
               st_nxt.dat[ppoc_pkg::CFG_GANG_BIT] = st_r.gang;
               if (wr) begin
                  st_nxt.gang = wb_dat_i[ppoc_pkg::CFG_GANG_BIT];
               end
            end
            ppoc_pkg::IDX_BC: begin
               st_nxt.dat[NPORT-1:0] = st_r.bc;
               if (wr) begin
                  st_nxt.bc = wb_dat_i[NPORT-1:0];
               end
            end
            ppoc_pkg::IDX_STAT: begin
               st_nxt.dat[NPORT-1:0] = st_r.stat;
               if (wr) begin
                  clr = wb_dat_i[NPORT-1:0];
               end
            end
            ppoc_pkg::IDX_MASK: begin
               st_nxt.dat[NPORT-1:0] = st_r.mask;
               if (wr) begin
                  st_nxt.mask = wb_dat_i[NPORT-1:0];
               end
            end
            ppoc_pkg::IDX_PIN: begin
               // Synchronised pin levels, useful for bring-up.
               st_nxt.dat[NPORT-1:0] = st_r.s2;
               st_nxt.dat[NPORT] = st_r.gs2;
            end
            default: begin
               // Unmapped addresses ack with zero and ignore writes.
               st_nxt.dat = '0;
            end
         endcase
      end

      // Read data stands only with ack, on writes too; the cycle after ack shows zero.
      if (!req) begin
         st_nxt.dat = '0;
      end

      // A mode change sends every port through a fresh turn-on, so in
      // ganged mode all filters run in step and flag together.
      if (st_nxt.gang != st_r.gang) begin
         for (int i = 0; i < NPORT; i++) begin
            st_nxt.ph[i] = ppoc_pkg::PH_OFF;
         end
      end

      // A detection in the clearing cycle wins over the clear.
      st_nxt.stat = (st_r.stat & ~clr) | oc;
      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
   end

   // State register; reset brings up individual mode, powers off.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.minw <= ppoc_pkg::MINW_RST;
         st_r.dblw <= ppoc_pkg::DBLW_RST;
         st_r.lock <= ppoc_pkg::LOCK_RST;
         st_r.oe <= '1;
         st_r.g_oe <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign wb_dat_o = st_r.dat;
   assign wb_ack_o = st_r.ack;
   assign port_power_sense_pin_out = st_r.drv;
   assign port_power_sense_pin_oe = st_r.oe;
   assign port_pullup_en = st_r.pu;
   // The ganged pin, like the port pins, only ever drives low.
   assign ganged_power_sense_pin_out = st_r.drv[0];
   assign ganged_power_sense_pin_oe = st_r.g_oe;
   assign ganged_pullup_en = st_r.g_pu;
   assign irq = st_r.irq;

endmodule // ppoc_port_power

// ---- hw/ppoc_pkg.sv ----
// Shared constants for the port power and overcurrent controller.
package ppoc_pkg;
   // Bus widths.
   localparam int ADR_W = 18;
   localparam int DAT_W = 32;
   // Register indices; the byte address is four times the index.
   localparam logic [15:0] IDX_LOCK = 16'h30e1;
   localparam logic [15:0] IDX_MINW = 16'h30ea;
   localparam logic [15:0] IDX_DBLW = 16'h30eb;
   localparam logic [15:0] IDX_PWR = 16'h3100;
   localparam logic [15:0] IDX_CFG = 16'h3101;
   localparam logic [15:0] IDX_BC = 16'h3102;
   localparam logic [15:0] IDX_STAT = 16'h3103;
   localparam logic [15:0] IDX_MASK = 16'h3104;
   localparam logic [15:0] IDX_PIN = 16'h3105;
   // Field layout.
   localparam int MINW_W = 4;
   localparam int TMR_W = 8;
   localparam int CFG_GANG_BIT = 0;
   // Reset values.
   localparam logic [MINW_W-1:0] MINW_RST = 4'h5;
   localparam logic [TMR_W-1:0] DBLW_RST = 8'h14;
   localparam logic [TMR_W-1:0] LOCK_RST = 8'h0a;
   // Timebase: one millisecond tick from the core clock.
   localparam int MS_NS = 1000000;
   localparam int CLK_NS = 20;
   localparam int TICK_CYC = MS_NS / CLK_NS;
   // Per-port power phase.
   typedef enum logic [1:0] {
      PH_OFF,
      PH_LOCK,
      PH_SENSE
   } ppoc_phase_t;
endpackage

// ---- dv/ppoc_switch_model.sv ----
`timescale 1ns/10ps
// Power switch on each pin: open-drain fault output, no drive otherwise.
module ppoc_switch_model #(
   parameter int N = 6
) (
   input wire logic clock,
   input wire logic [N-1:0] oe,
   input wire logic [N-1:0] pull_en,
   input wire logic [N-1:0] fault,
   output logic [N-1:0] level
);
   // A floating pin toggles so a stale level can never pass for a high.
   logic [N-1:0] float_r = '0;
   always_ff @(posedge clock) begin
      float_r <= ~float_r;
   end
   // Any low driver wins; the fault pulls low like the hub's driver.
   always_comb begin
      level = ~oe & ~fault & (pull_en | float_r);
   end
endmodule // ppoc_switch_model

// ---- dv/ppoc_port_power_sva.sv ----
`timescale 1ns/10ps
// Port-level checks for the power and overcurrent controller.
module ppoc_port_power_sva #(
   parameter int NPORT = 6,
   parameter int TICK_CYCLES = ppoc_pkg::TICK_CYC
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ppoc_pkg::DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [NPORT-1:0] port_power_sense_pin_out,
   input wire logic [NPORT-1:0] port_power_sense_pin_oe,
   input wire logic [NPORT-1:0] port_pullup_en,
   input wire logic ganged_power_sense_pin_out,
   input wire logic ganged_power_sense_pin_oe,
   input wire logic ganged_pullup_en,
   input wire logic irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // A request the slave has not yet answered.
   sequence bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // True when some pin is released, so sensing can run.
   wire logic any_on = ~&port_power_sense_pin_oe ||
      !ganged_power_sense_pin_oe;
   bus_ack_a: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single pulse after request");
   ack_cause_a: assert property (
      $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
      else $error("read data outside ack");
   drive_low_a: assert property (port_power_sense_pin_out == '0)
      else $error("port pin driven high");
   pin_mode_a: assert property (
      (port_power_sense_pin_oe ^ port_pullup_en) == '1)
      else $error("driver and pull-up not exclusive");
   gang_pin_a: assert property (
      ganged_power_sense_pin_oe != ganged_pullup_en)
      else $error("ganged driver and pull-up clash");
   gang_low_a: assert property (ganged_power_sense_pin_out == 1'b0)
      else $error("ganged pin driven high");
   // Power only moves two edges after a taken write.
   oe_cause_a: assert property ($changed({port_power_sense_pin_oe,
      ganged_power_sense_pin_oe}) |-> $past(wb_we_i && wb_stb_i, 2))
      else $error("power changed without write");
   irq_src_a: assert property (
      $rose(irq) |-> any_on || $past(any_on, 4))
      else $error("interrupt with every port off");
endmodule // ppoc_port_power_sva
bind ppoc_port_power ppoc_port_power_sva #(.NPORT(NPORT),
   .TICK_CYCLES(TICK_CYCLES)) i_sva (.clock(clock), .sys_rst(sys_rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .port_power_sense_pin_out(port_power_sense_pin_out),
   .port_power_sense_pin_oe(port_power_sense_pin_oe),
   .port_pullup_en(port_pullup_en),
   .ganged_power_sense_pin_out(ganged_power_sense_pin_out),
   .ganged_power_sense_pin_oe(ganged_power_sense_pin_oe),
   .ganged_pullup_en(ganged_pullup_en), .irq(irq));

// ---- dv/tb_ppoc_port_power.sv ----
`timescale 1ns/10ps
module tb_ppoc_port_power;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, g_in, g_oe, g_pu;
   logic g_fault = 1'b0;
   logic [3:0] sel = 4'hf;
   logic [17:0] adr = '0;
   logic [31:0] dat_i = '0, dat_o;
   logic [5:0] pin, oe, pu, fault = '0;
   int num_errors = 0;
   int total_checks = 0;
   always #10 clock = ~clock;
   // A short tick keeps millisecond timers to ten clocks.
   ppoc_port_power #(.NPORT(6), .TICK_CYCLES(10)) i_dut (.clock(clock),
      .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .port_power_sense_pin_in(pin),
      .port_power_sense_pin_out(), .port_power_sense_pin_oe(oe),
      .port_pullup_en(pu), .ganged_power_sense_pin_in(g_in),
      .ganged_power_sense_pin_out(), .ganged_power_sense_pin_oe(g_oe),
      .ganged_pullup_en(g_pu), .irq(irq));
   ppoc_switch_model #(.N(6)) i_sw (.clock(clock), .oe(oe), .pull_en(pu),
      .fault(fault), .level(pin));
   ppoc_switch_model #(.N(1)) i_gsw (.clock(clock), .oe(g_oe),
      .pull_en(g_pu), .fault(g_fault), .level(g_in));
   task automatic check(input string nm, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One classic cycle; the request holds until ack is sampled.
   task automatic wb(input logic w, input logic [15:0] i, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clock);
      {cyc, stb, we, adr, dat_i} <= {2'b11, w, i, 2'b00, d};
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) num_errors++;
      q = dat_o;
      {cyc, stb, we} <= 3'h0;
   endtask
   task automatic wr(input logic [15:0] i, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, i, d, q);
   endtask
   task automatic rd(input string nm, input logic [15:0] i,
      input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, i, 32'h0, q);
      check(nm, q, e);
   endtask
   task automatic t_regs;
      rd("lockout", ppoc_pkg::IDX_LOCK, 32'h0a);
      rd("min width", ppoc_pkg::IDX_MINW, 32'h05);
      rd("window", ppoc_pkg::IDX_DBLW, 32'h14);
      rd("mode", ppoc_pkg::IDX_CFG, 32'h0);
      rd("unmapped", 16'h3200, 32'h0);
      // A write whose lowest byte lane is off is dropped.
      sel <= 4'he;
      wr(ppoc_pkg::IDX_DBLW, 32'h0);
      sel <= 4'hf;
      rd("lane off", ppoc_pkg::IDX_DBLW, 32'h14);
      wr(ppoc_pkg::IDX_MINW, 32'hff);
      rd("reserved", ppoc_pkg::IDX_MINW, 32'h0f);
      wr(ppoc_pkg::IDX_MINW, 32'h2);
      wr(ppoc_pkg::IDX_LOCK, 32'h2);
   endtask
   // Lows in lockout are ignored; a held low then flags port 0.
   task automatic t_single;
      wr(ppoc_pkg::IDX_MASK, 32'h1);
      wr(ppoc_pkg::IDX_PWR, 32'h1);
      repeat (3) @(posedge clock);
      check("oe", oe, 32'h3e);
      check("pull-up", pu, 32'h1);
      fault[0] <= 1'b1;
      repeat (10) @(posedge clock);
      fault[0] <= 1'b0;
      repeat (25) @(posedge clock);
      check("irq lockout", irq, 1'b0);
      fault[0] <= 1'b1;
      repeat (30) @(posedge clock);
      fault[0] <= 1'b0;
      check("irq", irq, 1'b1);
      rd("status", ppoc_pkg::IDX_STAT, 32'h1);
      wr(ppoc_pkg::IDX_PWR, 32'h0);
      wr(ppoc_pkg::IDX_STAT, 32'h1);
      rd("cleared", ppoc_pkg::IDX_STAT, 32'h0);
      check("irq off", irq, 1'b0);
   endtask
   // Two short lows inside the window flag port 1, masked from irq.
   task automatic t_double;
      wr(ppoc_pkg::IDX_PWR, 32'h2);
      repeat (40) @(posedge clock);
      repeat (2) begin
         fault[1] <= 1'b1;
         repeat (5) @(posedge clock);
         fault[1] <= 1'b0;
         repeat (20) @(posedge clock);
      end
      rd("double", ppoc_pkg::IDX_STAT, 32'h2);
      check("irq masked", irq, 1'b0);
      wr(ppoc_pkg::IDX_PWR, 32'h0);
      wr(ppoc_pkg::IDX_STAT, 32'h3f);
      // A charging-capable port is powered through its pin like a
      // plain enable; the other pins stay driven low.
      wr(ppoc_pkg::IDX_BC, 32'h4);
      repeat (3) @(posedge clock);
      check("bc oe", oe, 32'h3b);
      check("bc pull-up", pu, 32'h4);
      rd("pins", ppoc_pkg::IDX_PIN, 32'h4);
      wr(ppoc_pkg::IDX_BC, 32'h0);
   endtask
   task automatic t_gang;
      wr(ppoc_pkg::IDX_CFG, 32'h1);
      wr(ppoc_pkg::IDX_PWR, 32'h1);
      repeat (3) @(posedge clock);
      check("gang oe", g_oe, 1'b0);
      check("gang pull-up", g_pu, 1'b1);
      check("ports low", oe, 32'h3f);
      repeat (40) @(posedge clock);
      g_fault <= 1'b1;
      repeat (40) @(posedge clock);
      g_fault <= 1'b0;
      rd("gang status", ppoc_pkg::IDX_STAT, 32'h3f);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // The run needs well under a thousand cycles; this cuts a hang.
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      t_regs();
      t_single();
      t_double();
      t_gang();
      stop_test();
   end
endmodule // tb_ppoc_port_power
